// ### core/nesc_ctrl.sv
// How it works
// - During power-up initialization only FFh or 70h may be issued.
// - Never issue commands outside the defined command set.
// - While busy, only 70h, 71h and FFh may be issued.
// - After 80h only 85h, 10h, 11h or FFh may follow.
// - Pages of a block are programmed in ascending order only. The code refuses only a page below the last programmed page of the same block.
// - Never erase a block marked bad.
//
// Our own choices: the register offsets and register access over APB.
`include "nesc_consts.svh"
`default_nettype none
module nesc_ctrl (
	input  wire logic            REF_CLK,
	input  wire logic            SYS_RST,
	input  wire logic            PSEL,
	input  wire logic            PENABLE,
	input  wire logic            PWRITE,
	input  wire logic [7:0]      PADDR,
	input  wire logic [31:0]     PWDATA,
	output var  logic [31:0]     PRDATA,
	output var  logic            PREADY,
	output var  logic            PSLVERR,
	output var  logic            CLE,
	output var  logic            ALE,
	output var  logic            CE_N,
	output var  logic            WE_N,
	output var  logic            READ_STROBE_N,
	output var  logic            WP_N,
	output var  logic [7:0]      IO_O,
	output var  logic            IO_OE,
	input  wire logic [7:0]      IO_I,
	input  wire logic            READY_BUSY_N
);
	import nesc_pkg::*;

	localparam int NB = `NESC_BAD_ENTRIES;

	nesc_state_e        state_r, state_nxt;
	nesc_op_e           kind_r, kind_nxt;
	nesc_pins_s         pins_r, pins_nxt;
	logic [31:0]        prdata_r, prdata_nxt;
	logic               pready_r, pready_nxt;
	logic               pslverr_r, pslverr_nxt;
	logic [1:0]         ctrl_r, ctrl_nxt;
	logic [47:0]        addr_r, addr_nxt;
	logic [2:0]         acnt_r, acnt_nxt;
	logic [2:0]         aidx_r, aidx_nxt;
	logic [3:0]         tcnt_r, tcnt_nxt;
	logic [7:0]         rdata_r, rdata_nxt;
	logic [7:0]         last_cmd_r, last_cmd_nxt;
	logic               init_r, init_nxt;
	logic               serial_r, serial_nxt;
	logic               refused_r, refused_nxt;
	logic [7:0]         ecc_byte_r, ecc_byte_nxt;
	logic [3:0]         ecc_max_r, ecc_max_nxt;
	logic               ecc_unc_r, ecc_unc_nxt;
	logic [3:0]         ecc_cnt_r, ecc_cnt_nxt;
	logic [11:0]        last_blk_r, last_blk_nxt;
	logic [5:0]         last_page_r, last_page_nxt;
	logic               prog_seen_r, prog_seen_nxt;
	logic [11:0]        pend_blk_r, pend_blk_nxt;
	logic [5:0]         pend_page_r, pend_page_nxt;
	logic [11:0]        bad_blk_r [NB];
	logic [NB-1:0]      bad_vld_r;
	logic [NB-1:0]      bad_hit;
	logic               bad_we;
	logic [2:0]         bad_idx;

	logic               wr;
	logic               op_go;
	logic               refuse;
	logic               known;
	logic [7:0]         op_byte;
	logic [2:0]         op_cnt;
	nesc_op_e           op_kind;
	logic [17:0]        row;

	// Row starts at the first row byte: page in its low six bits, block above
	assign row     = addr_r[33:16];
	assign op_byte = PWDATA[`NESC_OP_BYTE_LSB +: 8];
	assign op_cnt  = PWDATA[`NESC_OP_CNT_LSB +: 3];
	assign op_kind = nesc_op_e'(PWDATA[`NESC_OP_KIND_LSB +: 3]);
	assign wr      = PSEL && PENABLE && pready_r && PWRITE;
	assign op_go   = wr && (PADDR == `NESC_OFF_OP);
	assign bad_we  = wr && (PADDR == `NESC_OFF_BAD);
	assign bad_idx = PWDATA[`NESC_BAD_IDX_LSB +: 3];

	// Bad block table: one compare per entry against the addressed block
	for (genvar i = 0; i < NB; i++) begin : g_bad
		assign bad_hit[i] = bad_vld_r[i] && (bad_blk_r[i] == row[17:6]);
		always_ff @(posedge REF_CLK) begin
			if (SYS_RST) begin
				bad_vld_r[i] <= 1'b0;
				bad_blk_r[i] <= 12'h000;
			end else if (bad_we && (bad_idx == 3'(i))) begin
				bad_vld_r[i] <= PWDATA[`NESC_BAD_VALID];
				bad_blk_r[i] <= PWDATA[11:0];
			end
		end
	end

	always_comb begin
		unique case (op_byte)
			`NESC_CMD_READ, `NESC_CMD_RDCONF, `NESC_CMD_COPYRD, `NESC_CMD_COLRD,
			`NESC_CMD_COLRDC, `NESC_CMD_SERIN, `NESC_CMD_COLCHG, `NESC_CMD_PROG,
			`NESC_CMD_MPROG, `NESC_CMD_ERASE, `NESC_CMD_ERCONF, `NESC_CMD_STAT,
			`NESC_CMD_STAT2, `NESC_CMD_ID, `NESC_CMD_RESET, `NESC_CMD_ECC: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	always_comb begin
		refuse = (state_r != ST_IDLE);
		if (op_kind == OP_CMD) begin
			if (!known)
				refuse = 1'b1;
			if (!init_r && op_byte != `NESC_CMD_RESET && op_byte != `NESC_CMD_STAT)
				refuse = 1'b1;
			if (!READY_BUSY_N && op_byte != `NESC_CMD_STAT && op_byte != `NESC_CMD_STAT2
				&& op_byte != `NESC_CMD_RESET)
				refuse = 1'b1;
			if (serial_r && op_byte != `NESC_CMD_COLCHG && op_byte != `NESC_CMD_PROG
				&& op_byte != `NESC_CMD_MPROG && op_byte != `NESC_CMD_RESET)
				refuse = 1'b1;
		end else if (op_kind == OP_ADDR) begin
			if (op_cnt != 3'h3 && op_cnt != 3'h5 && op_cnt != 3'h6)
				refuse = 1'b1;
			if (last_cmd_r == `NESC_CMD_SERIN && prog_seen_r && row[17:6] == last_blk_r
				&& row[5:0] < last_page_r)
				refuse = 1'b1;
			if (last_cmd_r == `NESC_CMD_ERASE && |bad_hit)
				refuse = 1'b1;
		end else if (op_kind == OP_NONE || op_kind > OP_WAIT) begin
			refuse = 1'b1;
		end
	end

	always_comb begin
		state_nxt     = state_r;
		kind_nxt      = kind_r;
		pins_nxt      = pins_r;
		prdata_nxt    = prdata_r;
		pready_nxt    = 1'b0;
		pslverr_nxt   = 1'b0;
		ctrl_nxt      = ctrl_r;
		addr_nxt      = addr_r;
		acnt_nxt      = acnt_r;
		aidx_nxt      = aidx_r;
		tcnt_nxt      = tcnt_r;
		rdata_nxt     = rdata_r;
		last_cmd_nxt  = last_cmd_r;
		init_nxt      = init_r | READY_BUSY_N;
		serial_nxt    = serial_r;
		refused_nxt   = refused_r;
		ecc_byte_nxt  = ecc_byte_r;
		ecc_max_nxt   = ecc_max_r;
		ecc_unc_nxt   = ecc_unc_r;
		ecc_cnt_nxt   = ecc_cnt_r;
		last_blk_nxt  = last_blk_r;
		last_page_nxt = last_page_r;
		prog_seen_nxt = prog_seen_r;
		pend_blk_nxt  = pend_blk_r;
		pend_page_nxt = pend_page_r;

		// Bus: answer one cycle after the setup cycle
		if (PSEL && !PENABLE) begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0000_0000;
			unique case (PADDR)
				`NESC_OFF_CTRL:   prdata_nxt = {30'h0, ctrl_r};
				`NESC_OFF_OP:     prdata_nxt = {29'h0, kind_r};
				`NESC_OFF_ADDRLO: prdata_nxt = addr_r[31:0];
				`NESC_OFF_ADDRHI: prdata_nxt = {16'h0, addr_r[47:32]};
				`NESC_OFF_STATUS: prdata_nxt = {16'h0, rdata_r, 3'h0, refused_r, serial_r,
					init_r, READY_BUSY_N, (state_r != ST_IDLE)};
				`NESC_OFF_ECC:    prdata_nxt = {15'h0, ecc_cnt_r, ecc_unc_r, ecc_max_r,
					ecc_byte_r};
				`NESC_OFF_BAD:    prdata_nxt = {24'h0, bad_vld_r};
				default:          pslverr_nxt = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (PADDR)
				`NESC_OFF_CTRL:   ctrl_nxt = PWDATA[1:0];
				`NESC_OFF_ADDRLO: addr_nxt[31:0] = PWDATA;
				`NESC_OFF_ADDRHI: addr_nxt[47:32] = PWDATA[15:0];
				`NESC_OFF_STATUS: if (PWDATA[`NESC_ST_REFUSED]) refused_nxt = 1'b0;
				default: ;
			endcase
		end
		pins_nxt.ce_n = !ctrl_r[`NESC_CTRL_CE];
		pins_nxt.wp_n = ctrl_r[`NESC_CTRL_WP_REL];

		// Launch of one pin operation
		if (op_go && refuse) begin
			refused_nxt = 1'b1;
		end else if (op_go) begin
			kind_nxt = op_kind;
			unique case (op_kind)
				OP_CMD: begin
					pins_nxt.cle  = 1'b1;
					pins_nxt.io_o = op_byte;
					pins_nxt.io_oe = 1'b1;
					state_nxt = ST_SETUP;
					last_cmd_nxt = op_byte;
					if (op_byte == `NESC_CMD_SERIN)
						serial_nxt = 1'b1;
					else if (op_byte != `NESC_CMD_COLCHG)
						serial_nxt = 1'b0;
					if (serial_r && (op_byte == `NESC_CMD_PROG || op_byte == `NESC_CMD_MPROG))
						begin
						last_blk_nxt  = pend_blk_r;
						last_page_nxt = pend_page_r;
						prog_seen_nxt = 1'b1;
					end
					if (op_byte == `NESC_CMD_ECC) begin
						ecc_cnt_nxt = 4'h0;
						ecc_max_nxt = 4'h0;
						ecc_unc_nxt = 1'b0;
					end
				end
				OP_ADDR: begin
					// Three cycles carry the row only; a sixth byte is sent as given
					aidx_nxt = (op_cnt == 3'h3) ? 3'h2 : 3'h0;
					acnt_nxt = op_cnt - 3'h1;
					pins_nxt.ale = 1'b1;
					pins_nxt.io_o = addr_r[{((op_cnt == 3'h3) ? 3'h2 : 3'h0), 3'h0} +: 8];
					pins_nxt.io_oe = 1'b1;
					state_nxt = ST_SETUP;
					if (last_cmd_r == `NESC_CMD_SERIN) begin
						pend_blk_nxt  = row[17:6];
						pend_page_nxt = row[5:0];
					end
				end
				OP_WDATA: begin
					pins_nxt.io_o = op_byte;
					pins_nxt.io_oe = 1'b1;
					state_nxt = ST_SETUP;
				end
				OP_RDATA: begin
					pins_nxt.io_oe = 1'b0;
					pins_nxt.re_n = 1'b0;
					tcnt_nxt = 4'(`NESC_STROBE_CYC - 1);
					state_nxt = ST_RDLOW;
				end
				default: begin
					tcnt_nxt = 4'(`NESC_WB_CYC);
					state_nxt = ST_WAIT;
				end
			endcase
		end

		unique case (state_r)
			ST_IDLE: ;
			ST_SETUP: begin
				pins_nxt.we_n = 1'b0;
				tcnt_nxt = 4'(`NESC_STROBE_CYC - 1);
				state_nxt = ST_STROBE;
			end
			ST_STROBE: begin
				if (tcnt_r == 4'h0) begin
					pins_nxt.we_n = 1'b1;
					state_nxt = ST_HOLD;
				end else begin
					tcnt_nxt = tcnt_r - 4'h1;
				end
			end
			ST_HOLD: begin
				if (kind_r == OP_ADDR && acnt_r != 3'h0) begin
					acnt_nxt = acnt_r - 3'h1;
					aidx_nxt = aidx_r + 3'h1;
					pins_nxt.io_o = addr_r[{aidx_r + 3'h1, 3'h0} +: 8];
					state_nxt = ST_SETUP;
				end else begin
					pins_nxt.cle = 1'b0;
					pins_nxt.ale = 1'b0;
					pins_nxt.io_oe = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			ST_RDLOW: begin
				if (tcnt_r == 4'h0) begin
					pins_nxt.re_n = 1'b1;
					rdata_nxt = IO_I;
					state_nxt = ST_HOLD;
					if (last_cmd_r == `NESC_CMD_ECC) begin
						ecc_byte_nxt = IO_I;
						ecc_cnt_nxt = ecc_cnt_r + 4'h1;
						if (IO_I[7:4] <= `NESC_ECC_SECMAX) begin
							if (IO_I[3:0] == `NESC_ECC_UNCORR)
								ecc_unc_nxt = 1'b1;
							else if (IO_I[3:0] <= `NESC_ECC_MAXCNT && IO_I[3:0] > ecc_max_r)
								ecc_max_nxt = IO_I[3:0];
						end
					end
				end else begin
					tcnt_nxt = tcnt_r - 4'h1;
				end
			end
			ST_WAIT: begin
				if (tcnt_r != 4'h0)
					tcnt_nxt = tcnt_r - 4'h1;
				else if (READY_BUSY_N)
					state_nxt = ST_IDLE;
			end
		endcase
		// A refusal raised in the same cycle as its clear survives
		if (op_go && refuse)
			refused_nxt = 1'b1;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_r     <= ST_IDLE;
			kind_r      <= OP_NONE;
			pins_r      <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
				wp_n: 1'b0, io_oe: 1'b0, io_o: 8'h00};
			prdata_r    <= 32'h0000_0000;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
			ctrl_r      <= `NESC_CTRL_RST;
			addr_r      <= 48'h0000_0000_0000;
			acnt_r      <= 3'h0;
			aidx_r      <= 3'h0;
			tcnt_r      <= 4'h0;
			rdata_r     <= 8'h00;
			last_cmd_r  <= 8'h00;
			init_r      <= 1'b0;
			serial_r    <= 1'b0;
			refused_r   <= 1'b0;
			ecc_byte_r  <= 8'h00;
			ecc_max_r   <= 4'h0;
			ecc_unc_r   <= 1'b0;
			ecc_cnt_r   <= 4'h0;
			last_blk_r  <= 12'h000;
			last_page_r <= 6'h00;
			prog_seen_r <= 1'b0;
			pend_blk_r  <= 12'h000;
			pend_page_r <= 6'h00;
		end else begin
			state_r     <= state_nxt;
			kind_r      <= kind_nxt;
			pins_r      <= pins_nxt;
			prdata_r    <= prdata_nxt;
			pready_r    <= pready_nxt;
			pslverr_r   <= pslverr_nxt;
			ctrl_r      <= ctrl_nxt;
			addr_r      <= addr_nxt;
			acnt_r      <= acnt_nxt;
			aidx_r      <= aidx_nxt;
			tcnt_r      <= tcnt_nxt;
			rdata_r     <= rdata_nxt;
			last_cmd_r  <= last_cmd_nxt;
			init_r      <= init_nxt;
			serial_r    <= serial_nxt;
			refused_r   <= refused_nxt;
			ecc_byte_r  <= ecc_byte_nxt;
			ecc_max_r   <= ecc_max_nxt;
			ecc_unc_r   <= ecc_unc_nxt;
			ecc_cnt_r   <= ecc_cnt_nxt;
			last_blk_r  <= last_blk_nxt;
			last_page_r <= last_page_nxt;
			prog_seen_r <= prog_seen_nxt;
			pend_blk_r  <= pend_blk_nxt;
			pend_page_r <= pend_page_nxt;
		end
	end

	assign PRDATA        = prdata_r;
	assign PREADY        = pready_r;
	assign PSLVERR       = pslverr_r;
	assign CLE           = pins_r.cle;
	assign ALE           = pins_r.ale;
	assign CE_N          = pins_r.ce_n;
	assign WE_N          = pins_r.we_n;
	assign READ_STROBE_N = pins_r.re_n;
	assign WP_N          = pins_r.wp_n;
	assign IO_O          = pins_r.io_o;
	assign IO_OE         = pins_r.io_oe;
endmodule
`default_nettype wire

// ### core/nesc_consts.svh
`ifndef NESC_CONSTS_SVH
`define NESC_CONSTS_SVH

// Register byte offsets
`define NESC_OFF_CTRL    8'h00
`define NESC_OFF_OP      8'h04
`define NESC_OFF_ADDRLO  8'h08
`define NESC_OFF_ADDRHI  8'h0c
`define NESC_OFF_STATUS  8'h10
`define NESC_OFF_ECC     8'h14
`define NESC_OFF_BAD     8'h18

// Control fields
`define NESC_CTRL_WP_REL 0
`define NESC_CTRL_CE     1
`define NESC_CTRL_RST    2'h0

// Operation word fields
`define NESC_OP_KIND_LSB 0
`define NESC_OP_BYTE_LSB 8
`define NESC_OP_CNT_LSB  16

// Status fields
`define NESC_ST_REFUSED  4

// Bad block table entry fields
`define NESC_BAD_VALID   15
`define NESC_BAD_IDX_LSB 12
`define NESC_BAD_ENTRIES 8

// Command codes
`define NESC_CMD_READ    8'h00
`define NESC_CMD_RDCONF  8'h30
`define NESC_CMD_COPYRD  8'h35
`define NESC_CMD_COLRD   8'h05
`define NESC_CMD_COLRDC  8'he0
`define NESC_CMD_SERIN   8'h80
`define NESC_CMD_COLCHG  8'h85
`define NESC_CMD_PROG    8'h10
`define NESC_CMD_MPROG   8'h11
`define NESC_CMD_ERASE   8'h60
`define NESC_CMD_ERCONF  8'hd0
`define NESC_CMD_STAT    8'h70
`define NESC_CMD_STAT2   8'h71
`define NESC_CMD_ID      8'h90
`define NESC_CMD_RESET   8'hff
`define NESC_CMD_ECC     8'h7a

// ECC report codes
`define NESC_ECC_UNCORR  4'hf
`define NESC_ECC_MAXCNT  4'h8
`define NESC_ECC_SECMAX  4'h7

// Timing: clock period, strobe width and busy wait in ns
`define NESC_CLK_NS      40
`define NESC_STROBE_NS   40
`define NESC_WB_NS       100
`define NESC_STROBE_CYC  ((`NESC_STROBE_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)
`define NESC_WB_CYC      ((`NESC_WB_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)

`endif

// ### core/nesc_pkg.sv
`default_nettype none
package nesc_pkg;
	typedef enum logic [2:0] {
		OP_NONE, OP_CMD, OP_ADDR, OP_WDATA, OP_RDATA, OP_WAIT
	} nesc_op_e;

	typedef enum {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RDLOW, ST_WAIT
	} nesc_state_e;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ce_n;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic       io_oe;
		logic [7:0] io_o;
	} nesc_pins_s;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} nesc_apb_s;
endpackage
`default_nettype wire

// ### tb/nesc_monitor.sv
`default_nettype none
module nesc_monitor (
	input wire logic       REF_CLK,
	input wire logic       SYS_RST,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PREADY,
	input wire logic       PSLVERR,
	input wire logic       CLE,
	input wire logic       ALE,
	input wire logic       CE_N,
	input wire logic       WE_N,
	input wire logic       READ_STROBE_N,
	input wire logic       WP_N,
	input wire logic       IO_OE,
	input wire logic [7:0] IO_O,
	input wire logic       READY_BUSY_N
);
	timeunit 1ns;
	timeprecision 1ns;
	logic init_r;
	logic open_r;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_cmd; $fell(WE_N) && CLE; endsequence
	// Power-up ready seen, and whether the last command opened serial input
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			init_r <= 1'b0;
			open_r <= 1'b0;
		end else begin
			init_r <= init_r | READY_BUSY_N;
			if ($fell(WE_N) && CLE) open_r <= (IO_O == 8'h80);
		end
	end
	property p_apb_answer; PSEL && !PENABLE |=> PREADY; endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("no answer after setup");
	property p_ready_pulse; PREADY |=> !PREADY; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	property p_err_qual; PSLVERR |-> PREADY; endproperty
	a_err_qual: assert property (p_err_qual) else $error("error without ready");
	property p_we_pulse; $fell(WE_N) |-> IO_OE ##1 WE_N; endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("bad write strobe");
	property p_rd_pulse; $fell(READ_STROBE_N) |-> !IO_OE ##1 READ_STROBE_N; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("bad read strobe");
	property p_latch_excl; !(CLE && ALE); endproperty
	a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
	property p_rst_pins; $past(SYS_RST) |-> CE_N && !WP_N && WE_N && !PREADY; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins not idle after reset");
	property p_known_cmd; s_cmd |-> IO_O inside {8'h00, 8'h05, 8'h10, 8'h11, 8'h30, 8'h35,
		8'h60, 8'h70, 8'h71, 8'h7a, 8'h80, 8'h85, 8'h90, 8'hd0, 8'he0, 8'hff}; endproperty
	a_known_cmd: assert property (p_known_cmd) else $error("unknown command");
	property p_init_cmd; s_cmd ##0 !init_r |-> IO_O inside {8'hff, 8'h70}; endproperty
	a_init_cmd: assert property (p_init_cmd) else $error("command during power-up");
	property p_busy_cmd; s_cmd ##0 !READY_BUSY_N |-> IO_O inside {8'h70, 8'h71, 8'hff}; endproperty
	a_busy_cmd: assert property (p_busy_cmd) else $error("command while busy");
	property p_serin; s_cmd ##0 open_r |-> IO_O inside {8'h85, 8'h10, 8'h11, 8'hff}; endproperty
	a_serin: assert property (p_serin) else $error("bad command after serial input");
endmodule
`default_nettype wire

// ### tb/nesc_flash_model.sv
`default_nettype none
module nesc_flash_model #(
	parameter int INIT_CYC = 200,
	parameter int PROG_CYC = 150
) (
	input wire logic       clk,
	input wire logic       cle,
	input wire logic       ce_n,
	input wire logic       we_n,
	input wire logic       re_n,
	input wire logic       wp_n,
	input wire logic [7:0] din,
	output logic     [7:0] dout,
	output logic           rb_low
);
	timeunit 1ns;
	timeprecision 1ns;
	int         busy = INIT_CYC;
	logic       pwe = 1'b1, pre = 1'b1, smode = 1'b0, emode = 1'b0;
	logic       pend = 1'b0, prog = 1'b0, fail = 1'b0;
	logic [2:0] eidx = 3'h0;
	logic [7:0] col = 8'h0, lastv = 8'h0, cur;
	logic [3:0] ecnt [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hf};
	always_comb begin
		if (emode) cur = {1'b0, eidx, ecnt[eidx]};
		else if (smode) cur = {wp_n, busy == 0, busy == 0, 4'h0, fail};
		else cur = col ^ 8'h5a;
	end
	// Released bus shows the inverse of the last byte
	assign dout = re_n ? ~lastv : cur;
	assign rb_low = busy != 0;
	always @(posedge clk) begin
		pwe <= we_n;
		pre <= re_n;
		if (busy != 0) busy <= busy - 1;
		if (busy != 0 && prog && !wp_n) begin
			busy <= 0;
			fail <= 1'b1;
		end
		// Only command cycles are decoded; address bytes, a sixth one too, change nothing
		if (!ce_n && cle && we_n && !pwe) begin
			case (din)
				8'hff: begin
					busy <= 3;
					{prog, pend, smode, emode} <= 4'h0;
				end
				8'h70: {smode, emode} <= 2'b10;
				8'h00: {smode, emode} <= 2'b00;
				8'h7a: {emode, eidx} <= 4'h8;
				8'h80: pend <= 1'b1;
				8'h85: ;
				8'h10, 8'h11: if (pend) begin
					{busy, prog, pend, fail} <= {PROG_CYC, 3'b100};
				end
				8'h30: {busy, prog, col} <= {PROG_CYC, 9'h0};
				default: pend <= 1'b0;
			endcase
		end
		if (!ce_n && re_n && !pre) begin
			lastv <= cur;
			if (emode) eidx <= eidx + 3'h1;
			else if (!smode) col <= col + 8'h1;
		end
	end
endmodule
`default_nettype wire

// ### tb/nesc_ctrl_test.sv
`include "nesc_consts.svh"
`default_nettype none
module nesc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import nesc_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, serr;
	logic        cle, ale, ce_n, we_n, re_n, wp_n, io_oe, rb_low, rb_n;
	logic [7:0]  paddr = 0, io_o, dout, bus;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  ecx [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hf};
	int          err_total = 0, compares = 0;
	assign bus = io_oe ? io_o : dout;
	assign rb_n = rb_low ? 1'b0 : 1'b1;
	nesc_ctrl nesc_ctrl_inst (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CLE(cle), .ALE(ale), .CE_N(ce_n), .WE_N(we_n),
		.READ_STROBE_N(re_n), .WP_N(wp_n), .IO_O(io_o), .IO_OE(io_oe), .IO_I(bus),
		.READY_BUSY_N(rb_n));
	nesc_flash_model nesc_flash_model_inst (.clk(clk), .cle(cle), .ce_n(ce_n), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .din(bus), .dout(dout), .rb_low(rb_low));
	initial forever #20 clk = ~clk;
	task automatic report_and_stop();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		{psel, pen} <= 2'b00;
	endtask
	task automatic op(input logic [2:0] k, input logic [7:0] b, input logic [2:0] n);
		apb(1'b1, `NESC_OFF_OP, {13'h0, n, b, 5'h0, k});
		do apb(1'b0, `NESC_OFF_STATUS, 32'h0);
		while (rd[0] !== 1'b0);
	endtask
	task automatic cmd(input logic [7:0] b);
		op(3'h1, b, 3'h0);
	endtask
	task automatic refd(input logic e);
		apb(1'b0, `NESC_OFF_STATUS, 32'h0);
		chk({31'h0, rd[4]}, {31'h0, e});
		apb(1'b1, `NESC_OFF_STATUS, 32'h10);
	endtask
	task automatic sbyte(input logic [7:0] e);
		op(3'h4, 8'h0, 3'h0);
		chk({24'h0, rd[15:8]}, {24'h0, e});
	endtask
	task automatic addr(input logic [31:0] lo, input logic [2:0] n);
		apb(1'b1, `NESC_OFF_ADDRLO, lo);
		apb(1'b1, `NESC_OFF_ADDRHI, 32'h0);
		op(3'h2, 8'h0, n);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `NESC_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h1c, 32'hffffffff);
		chk({31'h0, serr}, 32'h1);
		cmd(8'h80);
		refd(1'b1);
		cmd(8'h70);
		refd(1'b0);
		op(3'h5, 8'h0, 3'h0);
		chk(rd & 32'h6, 32'h6);
		apb(1'b1, `NESC_OFF_CTRL, 32'h3);
		cmd(8'h42);
		refd(1'b1);
		cmd(8'h70);
		sbyte(8'he0);
		cmd(8'h00);
		addr(32'h0, 3'h5);
		cmd(8'h30);
		op(3'h5, 8'h0, 3'h0);
		sbyte(8'h5a);
		sbyte(8'h5b);
		cmd(8'h70);
		sbyte(8'he0);
		cmd(8'h00);
		sbyte(8'h58);
		cmd(8'h7a);
		for (int i = 0; i < 8; i++) sbyte({i[3:0], ecx[i]});
		apb(1'b0, `NESC_OFF_ECC, 32'h0);
		chk(rd, 32'h1187f);
		cmd(8'h80);
		addr(32'h00450000, 3'h5);
		cmd(8'h70);
		refd(1'b1);
		cmd(8'h10);
		cmd(8'h70);
		cmd(8'h80);
		refd(1'b1);
		op(3'h5, 8'h0, 3'h0);
		cmd(8'h80);
		addr(32'h00440000, 3'h5);
		refd(1'b1);
		cmd(8'hff);
		op(3'h5, 8'h0, 3'h0);
		apb(1'b1, `NESC_OFF_BAD, 32'h8001);
		apb(1'b0, `NESC_OFF_BAD, 32'h0);
		chk(rd, 32'h1);
		cmd(8'h60);
		addr(32'h00450000, 3'h3);
		refd(1'b1);
		cmd(8'hff);
		op(3'h5, 8'h0, 3'h0);
		apb(1'b1, `NESC_OFF_CTRL, 32'h2);
		cmd(8'h80);
		addr(32'h00460000, 3'h5);
		op(3'h3, 8'ha5, 3'h0);
		cmd(8'h10);
		op(3'h5, 8'h0, 3'h0);
		cmd(8'h70);
		sbyte(8'h61);
		cmd(8'h80);
		addr(32'h00460000, 3'h6);
		refd(1'b0);
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
endmodule
bind nesc_ctrl nesc_monitor nesc_monitor_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .CLE(CLE),
	.ALE(ALE), .CE_N(CE_N), .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N), .WP_N(WP_N),
	.IO_OE(IO_OE), .IO_O(IO_O), .READY_BUSY_N(READY_BUSY_N));
`default_nettype wire
